/* include/rupw_pkg.sv */
/*
 * Package for the remote upgrade sequencer with user watchdog:
 * register layouts, reset values, field positions and states.
 * Assumes a single core clock and a separate watchdog oscillator clock.
 */
package rupw_pkg;

    // ------------------------------------------------------------
    // Register geometry
    // ------------------------------------------------------------
    localparam int RUPW_CTRL_W = 46;          // Control / update width
    localparam int RUPW_STAT_W = 5;           // Status width
    localparam int RUPW_TYPE_BIT = 0;         // Image type flag position
    localparam int RUPW_ADDR_LSB = 1;         // Start address low bit
    localparam int RUPW_ADDR_W = 32;          // Start address width
    localparam int RUPW_WDEN_BIT = 33;        // Watchdog enable position
    localparam int RUPW_WDTO_LSB = 34;        // Timeout field low bit
    localparam int RUPW_WDTO_W = 12;          // Timeout field width
    localparam int RUPW_WD_W = 29;            // Watchdog counter width
    localparam int RUPW_WD_LOW_W = 17;        // Counter bits below setting

    // Status bit positions
    localparam int RUPW_ST_CRC = 0;
    localparam int RUPW_ST_EXTERR = 1;
    localparam int RUPW_ST_CORE = 2;
    localparam int RUPW_ST_PIN = 3;
    localparam int RUPW_ST_WD = 4;

    // Reset values
    localparam logic [RUPW_CTRL_W-1:0] RUPW_CTRL_RST = 46'h0000_0000_0000;
    localparam logic [RUPW_STAT_W-1:0] RUPW_STAT_RST = 5'h00;
    localparam logic [RUPW_ADDR_W-1:0] RUPW_FACTORY_ADDR = 32'h0000_0020;

    // Flash pointer span holding the power-up start address
    localparam logic [7:0] RUPW_PTR_FIRST = 8'h00;
    localparam logic [7:0] RUPW_PTR_LAST = 8'h1F;

    // Shift register access codes
    typedef enum logic [1:0]
    {
        RUPW_SR_IDLE = 2'b00,
        RUPW_SR_SHIFT = 2'b01,
        RUPW_SR_CAP = 2'b10,
        RUPW_SR_UPD = 2'b11
    } rupw_sr_op_t;

    // Sequencer states
    typedef enum logic [2:0]
    {
        RUPW_S_POR = 3'b000,
        RUPW_S_LOAD = 3'b001,
        RUPW_S_USER = 3'b010,
        RUPW_S_FAIL = 3'b011
    } rupw_state_t;

    // Control / update register layout
    typedef struct packed
    {
        logic [RUPW_WDTO_W-1:0] watchdog_timeout_field;
        logic watchdog_enable_bit;
        logic [RUPW_ADDR_W-1:0] image_start_address;
        logic image_type_flag;
    } rupw_ctrl_t;

    // Result of a configuration load
    typedef struct packed
    {
        logic done;
        logic crc_error;
        logic ext_error;
    } rupw_load_t;

endpackage

/* logic/rupw_watchdog.sv */
/*
 * User watchdog counter, 29 bits, on the internal oscillator clock.
 * Assumes control inputs arrive from the core domain; run and restart
 * are synchronised here, the setting is used unsynchronised; the expiry event returns as a toggle.
 */
`timescale 1ns/100ps
module rupw_watchdog
    import rupw_pkg::*;
#(
    parameter int CNT_W = RUPW_WD_W,
    parameter int SET_W = RUPW_WDTO_W
)
(
    // Oscillator clock and reset
    input wire logic osc_clk,
    input wire logic osc_reset,
    // Core-side controls (other domain)
    input wire logic run,
    input wire logic restart_n,
    input wire logic [SET_W-1:0] setting,
    // Expiry toggle
    output logic expire_toggle
);

    // ------------------------------------------------------------
    // Synchronisers
    // ------------------------------------------------------------
    logic [1:0] run_sync;             // Run level
    logic [1:0] rst_sync;             // Restart level
    logic [CNT_W-1:0] count;          // Watchdog count
    logic fired;                      // Expired once this run

    // Timeout when upper bits equal the setting, low bits zero
    wire logic hit = (count[CNT_W-1 -: SET_W] == setting) && (count[CNT_W-SET_W-1:0] == '0);

    // Two-stage level capture
    always_ff @(posedge osc_clk)
    begin
        if (osc_reset)
        begin
            run_sync <= 2'h0;
            rst_sync <= 2'h3;
        end
        else
        begin
            run_sync <= {run_sync[0], run};
            rst_sync <= {rst_sync[0], restart_n};
        end
    end

    // Counter on the oscillator, not the user clock
    always_ff @(posedge osc_clk)
    begin
        if (osc_reset)
        begin
            count <= '0;
            fired <= 1'b0;
            expire_toggle <= 1'b0;
        end
        else if (!run_sync[1] || !rst_sync[1])
        begin
            // Held clear when off or restarted
            count <= '0;
            fired <= 1'b0;
        end
        else if (hit && !fired && count != '0)
        begin
            fired <= 1'b1;
            expire_toggle <= ~expire_toggle;
        end
        else if (!fired)
        begin
            count <= count + 1'b1;
        end
    end

endmodule

/* logic/rupw_sequencer.sv */
/*
 * Remote upgrade sequencer: update, control and status registers reached
 * through a shift register, power-up image choice, triggered
 * reconfiguration, error fallback and user watchdog supervision.
 * Assumes a loader outside reports load completion and errors, and the
 * watchdog oscillator is a separate free-running clock.
 */
`timescale 1ns/100ps

// Functional notes
// - Power-up clears registers, loads image from pointer
// - Request falling copies update into control, reconfigures
// - Error reverts factory, clears registers, records cause
// - Successful application load stays application
// - Watchdog off in factory, on in application
// - Only factory image may disable watchdog
// - Watchdog counter is 29 bits
// - Setting gives top 12 bits, step 2^17
// - Watchdog runs from internal oscillator
// - Watchdog counts from application user mode
// - Expiry raises timeout, sets cause, loads factory
// - Status reads zero after power-on reset
// - Bit 0 image type; application makes control read-only
// - Enable at bit 33, 12-bit timeout after
// - Status bits: CRC, external, core, pin, watchdog
// - Registers reached only via shift register
module rupw_sequencer
    import rupw_pkg::*;
(
    // Clocks and reset
    input wire logic CORE_CLK,
    input wire logic RESET,
    input wire logic WD_OSC_CLK,
    // Flash pointer read at power-up
    input wire logic [RUPW_ADDR_W-1:0] PTR_ADDRESS,
    input wire logic PTR_VALID,
    // Loader handshake
    input wire logic LOAD_DONE,
    input wire logic LOAD_CRC_ERROR,
    input wire logic EXTERNAL_ERROR_LINE,
    input wire logic PIN_RECONFIG_N,
    output logic LOAD_START,
    output logic [RUPW_ADDR_W-1:0] LOAD_ADDRESS,
    output logic USER_MODE,
    // User core shift access
    input wire logic SR_DIN,
    input wire logic [1:0] SR_OP,
    input wire logic [1:0] SR_SEL,
    output logic SR_DOUT,
    // User requests
    input wire logic RECONFIG_REQUEST_N,
    input wire logic WATCHDOG_RESTART_N,
    // Watchdog
    output logic WATCHDOG_TIMEOUT
);

    // ------------------------------------------------------------
    // Registers and state
    // ------------------------------------------------------------
    rupw_state_t state;               // Sequencer state
    rupw_ctrl_t ctrl;                 // Active control register
    rupw_ctrl_t upd;                  // Update register
    logic [RUPW_STAT_W-1:0] status;   // Trigger cause
    logic [RUPW_CTRL_W-1:0] shreg;    // User shift register
    logic [1:0] req_sync;             // Request pin synchroniser
    logic req_prev;                   // Request last sample
    logic [1:0] pin_sync;             // Config pin synchroniser
    logic [1:0] err_sync;             // External error synchroniser
    logic [2:0] wd_sync;              // Expiry toggle crossing
    logic wd_toggle;                  // From watchdog domain
    logic [1:0] osc_rst_sync;         // Reset into oscillator domain

    // ------------------------------------------------------------
    // Decoding
    // ------------------------------------------------------------
    wire rupw_sr_op_t op = rupw_sr_op_t'(SR_OP);
    wire logic req_fall = req_prev && !req_sync[1];
    wire logic wd_event = wd_sync[2] ^ wd_sync[1];
    wire logic in_app = (state == RUPW_S_USER) && ctrl.image_type_flag;
    // Enabled in application unless factory cleared it
    wire logic wd_run = in_app && ctrl.watchdog_enable_bit;
    wire logic load_err = LOAD_DONE && (LOAD_CRC_ERROR || err_sync[1]);
    // Pointer names an application image
    wire logic ptr_app = (PTR_ADDRESS != RUPW_FACTORY_ADDR);
    // Control writable only from factory image
    wire logic ctrl_wr_ok = !ctrl.image_type_flag;
    // Capture source by select
    wire logic [RUPW_CTRL_W-1:0] cap_src =
        (SR_SEL == 2'h0) ? RUPW_CTRL_W'(ctrl) :
        (SR_SEL == 2'h1) ? RUPW_CTRL_W'(upd) :
        {{(RUPW_CTRL_W-RUPW_STAT_W){1'b0}}, status};

    // Input synchronisers
    always_ff @(posedge CORE_CLK)
    begin
        if (RESET)
        begin
            req_sync <= 2'h3;
            req_prev <= 1'b1;
            pin_sync <= 2'h3;
            err_sync <= 2'h0;
            wd_sync <= 3'h0;
        end
        else
        begin
            req_sync <= {req_sync[0], RECONFIG_REQUEST_N};
            req_prev <= req_sync[1];
            pin_sync <= {pin_sync[0], PIN_RECONFIG_N};
            err_sync <= {err_sync[0], EXTERNAL_ERROR_LINE};
            wd_sync <= {wd_sync[1:0], wd_toggle};
        end
    end

    // Reset carried into the oscillator domain
    always_ff @(posedge WD_OSC_CLK)
    begin
        osc_rst_sync <= {osc_rst_sync[0], RESET};
    end

    // ------------------------------------------------------------
    // Shift register access
    // ------------------------------------------------------------
    // Registers reached only by shift, capture and update
    always_ff @(posedge CORE_CLK)
    begin
        if (RESET)
        begin
            shreg <= RUPW_CTRL_RST;
            SR_DOUT <= 1'b0;
        end
        else
        begin
            unique case (op)
                RUPW_SR_SHIFT: shreg <= {SR_DIN, shreg[RUPW_CTRL_W-1:1]};
                RUPW_SR_CAP: shreg <= cap_src;
                RUPW_SR_IDLE, RUPW_SR_UPD: shreg <= shreg;
            endcase
            SR_DOUT <= shreg[0];
        end
    end

    // ------------------------------------------------------------
    // Sequencer
    // ------------------------------------------------------------
    always_ff @(posedge CORE_CLK)
    begin
        if (RESET)
        begin
            // All upgrade registers zero after power-up
            state <= RUPW_S_POR;
            ctrl <= rupw_ctrl_t'(RUPW_CTRL_RST);
            upd <= rupw_ctrl_t'(RUPW_CTRL_RST);
            status <= RUPW_STAT_RST;
            LOAD_START <= 1'b0;
            LOAD_ADDRESS <= '0;
            USER_MODE <= 1'b0;
            WATCHDOG_TIMEOUT <= 1'b0;
        end
        else
        begin
            LOAD_START <= 1'b0;
            WATCHDOG_TIMEOUT <= 1'b0;
            unique case (state)
                RUPW_S_POR:
                begin
                    // Pointer from flash bytes 00..1F picks the image
                    if (PTR_VALID)
                    begin
                        ctrl.image_type_flag <= ptr_app;
                        // Factory keeps control at its cleared value
                        ctrl.image_start_address <= ptr_app ? PTR_ADDRESS : '0;
                        ctrl.watchdog_enable_bit <= ptr_app;
                        LOAD_ADDRESS <= PTR_ADDRESS;
                        LOAD_START <= 1'b1;
                        state <= RUPW_S_LOAD;
                    end
                end
                RUPW_S_LOAD:
                begin
                    if (load_err && ctrl.image_type_flag)
                    begin
                        state <= RUPW_S_FAIL;
                        status <= RUPW_STAT_RST;
                        status[RUPW_ST_CRC] <= LOAD_CRC_ERROR;
                        status[RUPW_ST_EXTERR] <= err_sync[1];
                    end
                    else if (LOAD_DONE)
                    begin
                        state <= RUPW_S_USER;
                        USER_MODE <= 1'b1;
                    end
                end
                RUPW_S_USER:
                begin
                    if (wd_event && wd_run)
                    begin
                        // Timeout pulse, cause, then factory
                        WATCHDOG_TIMEOUT <= 1'b1;
                        status <= RUPW_STAT_RST;
                        status[RUPW_ST_WD] <= 1'b1;
                        state <= RUPW_S_FAIL;
                        USER_MODE <= 1'b0;
                    end
                    else if (req_fall || !pin_sync[1])
                    begin
                        // Update copied into control, then reload
                        ctrl <= upd;
                        // Application cannot turn watchdog off
                        if (ctrl.image_type_flag)
                        begin
                            ctrl.watchdog_enable_bit <= 1'b1;
                        end
                        status <= RUPW_STAT_RST;
                        status[RUPW_ST_CORE] <= req_fall;
                        status[RUPW_ST_PIN] <= !pin_sync[1];
                        LOAD_ADDRESS <= upd.image_start_address;
                        LOAD_START <= 1'b1;
                        USER_MODE <= 1'b0;
                        state <= RUPW_S_LOAD;
                    end
                    else if (op == RUPW_SR_UPD)
                    begin
                        // Update, or control from the factory image, written from shift register
                        if (SR_SEL == 2'h1)
                        begin
                            upd <= rupw_ctrl_t'(shreg);
                        end
                        else if (SR_SEL == 2'h0 && ctrl_wr_ok)
                        begin
                            ctrl <= rupw_ctrl_t'(shreg);
                        end
                    end
                end
                RUPW_S_FAIL:
                begin
                    // Revert: control and update zero, load factory
                    ctrl <= rupw_ctrl_t'(RUPW_CTRL_RST);
                    upd <= rupw_ctrl_t'(RUPW_CTRL_RST);
                    LOAD_ADDRESS <= RUPW_FACTORY_ADDR;
                    LOAD_START <= 1'b1;
                    state <= RUPW_S_LOAD;
                end
                default:
                begin
                    state <= RUPW_S_POR;
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // Watchdog
    // ------------------------------------------------------------
    // 12-bit setting over 29-bit count, step 2^17
    rupw_watchdog #(
        .CNT_W(RUPW_WD_W),
        .SET_W(RUPW_WDTO_W)
    ) u_watchdog (
        .osc_clk(WD_OSC_CLK),
        .osc_reset(osc_rst_sync[1]),
        .run(wd_run),
        .restart_n(WATCHDOG_RESTART_N),
        .setting(ctrl.watchdog_timeout_field),
        .expire_toggle(wd_toggle)
    );

endmodule

/* verification/rupw_seq_assertions.sv */
/* Checker for the upgrade sequencer, bound to its top ports.
   Assumes one core clock domain and a synchronous active-high reset. */
`timescale 1ns/100ps
module rupw_seq_chk
    import rupw_pkg::*;
(
    // Clock and reset
    input wire logic CORE_CLK,
    input wire logic RESET,
    // Inputs watched
    input wire logic RECONFIG_REQUEST_N,
    input wire logic LOAD_DONE,
    input wire logic LOAD_CRC_ERROR,
    input wire logic EXTERNAL_ERROR_LINE,
    // Outputs watched
    input wire logic LOAD_START,
    input wire logic [RUPW_ADDR_W-1:0] LOAD_ADDRESS,
    input wire logic USER_MODE,
    input wire logic WATCHDOG_TIMEOUT
);
    default clocking cb @(posedge CORE_CLK);
    endclocking
    default disable iff (RESET);
    // Outputs stay low while reset is held
    a_reset_quiet: assert property (disable iff (1'b0)
        RESET |=> !LOAD_START && !USER_MODE && !WATCHDOG_TIMEOUT) else $error("output active in reset");
    a_request_start: assert property (
        $fell(RECONFIG_REQUEST_N) && USER_MODE |-> ##[2:5] LOAD_START) else $error("request not taken");
    a_start_user: assert property (
        LOAD_START |-> !USER_MODE) else $error("load started in user mode");
    a_leave_user: assert property (
        $fell(USER_MODE) |-> LOAD_START or (WATCHDOG_TIMEOUT ##1 LOAD_START))
        else $error("user mode left without load");
    a_done_user: assert property (
        LOAD_DONE && !LOAD_CRC_ERROR && !EXTERNAL_ERROR_LINE && !$past(EXTERNAL_ERROR_LINE)
        && !$past(EXTERNAL_ERROR_LINE, 2) && !$past(EXTERNAL_ERROR_LINE, 3) |=> USER_MODE)
        else $error("clean load not in user mode");
    a_err_fallback: assert property (
        LOAD_DONE && LOAD_CRC_ERROR && LOAD_ADDRESS != RUPW_FACTORY_ADDR
        |-> ##[1:3] (LOAD_START && LOAD_ADDRESS == RUPW_FACTORY_ADDR)) else $error("no factory fallback");
    a_timeout_loads: assert property (
        WATCHDOG_TIMEOUT |-> ##[0:8] (LOAD_START && LOAD_ADDRESS == RUPW_FACTORY_ADDR))
        else $error("timeout without factory load");
    a_timeout_pulse: assert property (
        WATCHDOG_TIMEOUT |=> !WATCHDOG_TIMEOUT) else $error("timeout longer than one cycle");
    // Main scenarios
    c_timeout: cover property (WATCHDOG_TIMEOUT);
    c_crc: cover property (LOAD_DONE && LOAD_CRC_ERROR);
    c_request: cover property ($fell(RECONFIG_REQUEST_N) && USER_MODE);
endmodule
bind rupw_sequencer rupw_seq_chk rupw_seq_chk_i (.CORE_CLK, .RESET, .RECONFIG_REQUEST_N, .LOAD_DONE,
    .LOAD_CRC_ERROR, .EXTERNAL_ERROR_LINE, .LOAD_START, .LOAD_ADDRESS, .USER_MODE, .WATCHDOG_TIMEOUT);

/* verification/rupw_user_model.sv */
/* User core model: shift register access, reconfiguration request
   and watchdog restart. Assumes all driving at the core rising edge. */
`timescale 1ns/100ps
module rupw_user_model
    import rupw_pkg::*;
(
    // Core clock
    input wire logic clk,
    // Shift access
    output logic sr_din,
    output logic [1:0] sr_op,
    output logic [1:0] sr_sel,
    input wire logic sr_dout,
    // Requests
    output logic req_n,
    output logic restart_n
);
    initial
    begin
        sr_din = 1'b0;
        sr_op = RUPW_SR_IDLE;
        sr_sel = 2'h0;
        req_n = 1'b1;
        restart_n = 1'b1;
    end
    // Capture, shift every bit LSB first, then update or idle
    task automatic access(input logic [1:0] sel, input logic [RUPW_CTRL_W-1:0] wd, input bit upd,
        output logic [RUPW_CTRL_W-1:0] rd);
        @(posedge clk);
        sr_op <= RUPW_SR_CAP;
        sr_sel <= sel;
        for (int i = 0; i <= RUPW_CTRL_W; i++)
        begin
            @(posedge clk);
            sr_op <= (i < RUPW_CTRL_W) ? RUPW_SR_SHIFT : (upd ? RUPW_SR_UPD : RUPW_SR_IDLE);
            sr_din <= wd[i % RUPW_CTRL_W];
            @(negedge clk);
            if (i > 0)
                rd[i-1] = sr_dout;
        end
        @(posedge clk);
        sr_op <= RUPW_SR_IDLE;
    endtask
    // One-cycle low request
    task automatic request();
        @(posedge clk);
        req_n <= 1'b0;
        @(posedge clk);
        req_n <= 1'b1;
    endtask
    // Hold the watchdog count clear for n cycles
    task automatic restart(input int n);
        @(posedge clk);
        restart_n <= 1'b0;
        repeat (n) @(posedge clk);
        restart_n <= 1'b1;
    endtask
endmodule

/* verification/tb_top.sv */
/* Self-checking bench: power-up load, triggered reconfiguration,
   error fallback and watchdog expiry. Assumes the user model and checker. */
`timescale 1ns/100ps
module tb_top;
    import rupw_pkg::*;
    localparam int W = RUPW_CTRL_W;
    localparam logic [RUPW_ADDR_W-1:0] APP = 32'h0001_0000;
    logic clk, rst, osc, ptr_valid, done, crc, ext, sr_din, sr_dout, req_n, wd_rst_n, start, user, tmo, pin_n;
    logic [1:0] sr_op, sr_sel;
    logic [RUPW_ADDR_W-1:0] laddr, ptr;
    logic [W-1:0] rd;
    rupw_ctrl_t upd_a, upd_b;
    int num_errors = 0;
    int n_checks = 0;
    int cyc = 0;
    int n;
    rupw_sequencer rupw_sequencer_i (.CORE_CLK(clk), .RESET(rst), .WD_OSC_CLK(osc),
        .PTR_ADDRESS(ptr), .PTR_VALID(ptr_valid), .LOAD_DONE(done), .LOAD_CRC_ERROR(crc),
        .EXTERNAL_ERROR_LINE(ext), .PIN_RECONFIG_N(pin_n), .LOAD_START(start), .LOAD_ADDRESS(laddr),
        .USER_MODE(user), .SR_DIN(sr_din), .SR_OP(sr_op), .SR_SEL(sr_sel), .SR_DOUT(sr_dout),
        .RECONFIG_REQUEST_N(req_n), .WATCHDOG_RESTART_N(wd_rst_n), .WATCHDOG_TIMEOUT(tmo));
    rupw_user_model rupw_user_model_i (.clk(clk), .sr_din(sr_din), .sr_op(sr_op), .sr_sel(sr_sel),
        .sr_dout(sr_dout), .req_n(req_n), .restart_n(wd_rst_n));
    // Core clock 40 ns, watchdog oscillator 2.2 ns
    initial
    begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    initial
    begin
        osc = 1'b0;
        forever #1.1 osc = ~osc;
    end
    // Hang guard
    always @(posedge clk)
    begin
        cyc <= cyc + 1;
        if (cyc == 45000)
        begin
            num_errors++;
            end_of_test();
        end
    end
    task automatic check(input string what, input logic [W-1:0] seen, exp);
        n_checks++;
        if (seen !== exp)
        begin
            num_errors++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    // Wait for a load start pulse, then check its address
    task automatic wait_start(input logic [RUPW_ADDR_W-1:0] a);
        int k;
        k = 0;
        while (start !== 1'b1 && k < 30)
        begin
            @(negedge clk);
            k++;
        end
        check("load start", W'(start), W'(1));
        check("load address", W'(laddr), W'(a));
    endtask
    task automatic load_done(input logic c);
        @(posedge clk);
        done <= 1'b1;
        crc <= c;
        @(posedge clk);
        done <= 1'b0;
        crc <= 1'b0;
    endtask
    // Count timeouts over n cycles
    task automatic quiet(input int n);
        int hits;
        hits = 0;
        repeat (n)
        begin
            @(negedge clk);
            hits += (tmo === 1'b0) ? 0 : 1;
        end
        check("timeout count", W'(hits), '0);
    endtask
    initial
    begin
        rst = 1'b1;
        ptr_valid = 1'b0;
        done = 1'b0;
        crc = 1'b0;
        ext = 1'b0;
        pin_n = 1'b1;
        ptr = RUPW_FACTORY_ADDR;
        upd_a = {12'h001, 1'b1, APP, 1'b1};
        upd_b = {12'h001, 1'b0, APP, 1'b1};
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        repeat (3) @(posedge clk);
        ptr_valid <= 1'b1;
        wait_start(RUPW_FACTORY_ADDR);
        @(posedge clk) ptr_valid <= 1'b0;
        load_done(1'b0);
        rupw_user_model_i.access(2'h2, '0, 0, rd);
        check("user mode", W'(user), W'(1));
        check("status", W'(rd[4:0]), W'(RUPW_STAT_RST));
        rupw_user_model_i.access(2'h0, '0, 0, rd);
        check("control", rd, RUPW_CTRL_RST);
        $display("test power-up finished");
        rupw_user_model_i.access(2'h1, upd_a, 1, rd);
        rupw_user_model_i.access(2'h1, '0, 0, rd);
        check("update", rd, upd_a);
        quiet(7600);
        rupw_user_model_i.request();
        wait_start(APP);
        load_done(1'b0);
        rupw_user_model_i.access(2'h2, '0, 0, rd);
        check("status", W'(rd[4:0]), W'(5'h04));
        rupw_user_model_i.access(2'h0, '0, 1, rd);
        rupw_user_model_i.access(2'h0, '0, 0, rd);
        check("control", rd, upd_a);
        $display("test application entry finished");
        repeat (3000) @(posedge clk);
        rupw_user_model_i.restart(4);
        n = 0;
        while (tmo !== 1'b1 && n < 8000)
        begin
            @(negedge clk);
            n++;
        end
        check("timeout delay", W'(n > 7100 && n < 7350), W'(1));
        wait_start(RUPW_FACTORY_ADDR);
        load_done(1'b0);
        rupw_user_model_i.access(2'h2, '0, 0, rd);
        check("status", W'(rd[4:0]), W'(5'h10));
        $display("test watchdog finished");
        for (int k = 0; k < 2; k++)
        begin
            rupw_user_model_i.access(2'h1, upd_b, 1, rd);
            rupw_user_model_i.request();
            wait_start(APP);
            @(posedge clk) ext <= k[0];
            repeat (4) @(posedge clk);
            load_done(k == 0);
            wait_start(RUPW_FACTORY_ADDR);
            @(posedge clk) ext <= 1'b0;
            load_done(1'b0);
            rupw_user_model_i.access(2'h2, '0, 0, rd);
            check("error cause", W'(rd[k]), W'(1));
            rupw_user_model_i.access(2'h0, '0, 0, rd);
            check("control cleared", rd, '0);
            rupw_user_model_i.access(2'h1, '0, 0, rd);
            check("update cleared", rd, '0);
        end
        $display("test error fallback finished");
        rupw_user_model_i.access(2'h1, upd_b, 1, rd);
        rupw_user_model_i.request();
        wait_start(APP);
        load_done(1'b0);
        quiet(7600);
        check("stays in application", W'(user), W'(1));
        $display("test watchdog off finished");
        // Pin trigger from the application: enable comes back on
        @(posedge clk) pin_n <= 1'b0;
        @(posedge clk) pin_n <= 1'b1;
        wait_start(APP);
        load_done(1'b0);
        rupw_user_model_i.access(2'h2, '0, 0, rd);
        check("status", W'(rd[4:0]), W'(5'h08));
        rupw_user_model_i.access(2'h0, '0, 0, rd);
        check("control", rd, upd_a);
        n = 0;
        while (tmo !== 1'b1 && n < 8000)
        begin
            @(negedge clk);
            n++;
        end
        check("forced watchdog", W'(n > 7000 && n < 7300), W'(1));
        wait_start(RUPW_FACTORY_ADDR);
        $display("test pin trigger finished");
        // Second reset with an application start pointer
        @(posedge clk) rst <= 1'b1;
        ptr <= APP;
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        repeat (3) @(posedge clk);
        ptr_valid <= 1'b1;
        wait_start(APP);
        @(posedge clk) ptr_valid <= 1'b0;
        load_done(1'b0);
        rupw_user_model_i.access(2'h2, '0, 0, rd);
        check("status", W'(rd[4:0]), W'(RUPW_STAT_RST));
        rupw_user_model_i.access(2'h0, '0, 0, rd);
        check("control", rd, W'({12'h000, 1'b1, APP, 1'b1}));
        $display("test application power-up finished");
        end_of_test();
    end
endmodule
